/* File: core/reference_clock_generator.sv */
// reference clock generator with avalon-mm register slave
//
// Function
// - the 4-bit source select chooses system, peripheral bus, primary, fast rc, low rc, secondary, usb pll, system pll or external input for codes 0 to 8.
// - run-in-sleep is ignored when source select is 0 or 1.
// - while enabled, a new divider is held pending until the switch request bit is set.
// - the trim register holds a 9-bit trim in bits 31 to 23, reset to zero, other bits read zero.
// - while enabled, a trim write waits for the switch request bit before taking effect.
// - the switch request bit reads 1 during a switch and is cleared by hardware when done.
// - a read-only request-active bit reads 1 while a clock request is active.
// - the enable bit turns the generator on at 1 and off at 0.
// - with run-in-sleep at 1 the output runs in sleep, at 0 it stops in sleep.
`timescale 1ns/100ps
`default_nettype none
module reference_clock_generator (
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic [3:0]                         address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [31:0]                        writedata,
  input  wire logic [3:0]                         byteenable,
  output logic      [31:0]                        readdata,
  output logic                                    waitrequest,
  input  wire logic [refclk_pkg::NUM_SOURCES-1:0] source_clocks,
  input  wire logic                               sleep_mode,
  output logic                                    reference_out
);

  // ------------------------------------------------------------
  // source synchronisers
  // ------------------------------------------------------------
  logic [refclk_pkg::NUM_SOURCES-1:0] sync1_reg;
  logic [refclk_pkg::NUM_SOURCES-1:0] sync2_reg;
  logic                               sleep1_reg;
  logic                               sleep2_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      sleep1_reg <= 1'b0;
      sleep2_reg <= 1'b0;
    end else begin
      sync1_reg  <= source_clocks;
      sync2_reg  <= sync1_reg;
      sleep1_reg <= sleep_mode;
      sleep2_reg <= sleep1_reg;
    end
  end

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [14:0] div_pend_reg,   div_pend_next;
  logic [8:0]  trim_pend_reg,  trim_pend_next;
  logic [3:0]  sel_reg,        sel_next;
  logic        enable_reg,     enable_next;
  logic        sleep_run_reg,  sleep_run_next;
  logic        switch_reg,     switch_next;
  logic        wait_reg,       wait_next;
  logic [31:0] rdata_reg,      rdata_next;
  refclk_pkg::divider_set_type act_reg, act_next;
  logic        boundary;
  logic        active;
  logic        wr_ctl;
  logic        wr_trim;
  logic        sw_set;
  logic        wreq_reg,       wreq_next;

  // writes land at the edge where waitrequest is sampled low
  assign wr_ctl  = write && wait_reg && (address == refclk_pkg::ADDR_CONTROL);
  assign wr_trim = write && wait_reg && (address == refclk_pkg::ADDR_TRIM);
  assign sw_set  = wr_ctl && byteenable[1] && writedata[refclk_pkg::SWITCH_BIT];

  always_comb begin
    div_pend_next  = div_pend_reg;
    trim_pend_next = trim_pend_reg;
    sel_next       = sel_reg;
    enable_next    = enable_reg;
    sleep_run_next = sleep_run_reg;
    switch_next    = switch_reg;
    act_next       = act_reg;
    rdata_next     = 32'h0000_0000;
    wait_next      = (read || write) && wait_reg;
    if ((read || write) && wait_reg) begin
      wait_next = 1'b0;
    end else if (read || write) begin
      wait_next = 1'b1;
    end
    wreq_next = !wait_next;
    if (wr_ctl) begin
      if (byteenable[0]) begin
        sel_next = writedata[3:0];
      end
      if (byteenable[1]) begin
        enable_next    = writedata[refclk_pkg::ENABLE_BIT];
        sleep_run_next = writedata[refclk_pkg::SLEEP_BIT];
        if (writedata[refclk_pkg::SWITCH_BIT]) begin
          switch_next = 1'b1;
        end
      end
      if (byteenable[2] && byteenable[3]) begin
        div_pend_next = writedata[30:16];
      end
    end
    if (wr_trim && byteenable[3] && byteenable[2]) begin
      trim_pend_next = writedata[31:23];
    end
    // load pending set: immediately when off, at a boundary on switch request
    if (!enable_reg) begin
      act_next.divider = div_pend_next;
      act_next.trim    = trim_pend_next;
      switch_next      = 1'b0;
    end else if (switch_reg && boundary) begin
      act_next.divider = div_pend_reg;
      act_next.trim    = trim_pend_reg;
      // a new switch request in the same cycle wins over the clear
      if (!sw_set) begin
        switch_next = 1'b0;
      end
    end
    if (read && !wait_reg) begin
      if (address == refclk_pkg::ADDR_CONTROL) begin
        rdata_next[30:16]                    = div_pend_reg;
        rdata_next[refclk_pkg::ENABLE_BIT]   = enable_reg;
        rdata_next[refclk_pkg::SLEEP_BIT]    = sleep_run_reg;
        rdata_next[refclk_pkg::SWITCH_BIT]   = switch_reg;
        rdata_next[refclk_pkg::ACTIVE_BIT]   = active;
        rdata_next[3:0]                      = sel_reg;
      end else if (address == refclk_pkg::ADDR_TRIM) begin
        rdata_next[31:23] = trim_pend_reg;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_pend_reg  <= refclk_pkg::DIV_RESET;
      trim_pend_reg <= refclk_pkg::TRIM_RESET;
      sel_reg       <= refclk_pkg::SEL_RESET;
      enable_reg    <= 1'b0;
      sleep_run_reg <= 1'b0;
      switch_reg    <= 1'b0;
      wait_reg      <= 1'b0;
      wreq_reg      <= 1'b1;
      rdata_reg     <= 32'h0000_0000;
      act_reg       <= '0;
    end else begin
      div_pend_reg  <= div_pend_next;
      trim_pend_reg <= trim_pend_next;
      sel_reg       <= sel_next;
      enable_reg    <= enable_next;
      sleep_run_reg <= sleep_run_next;
      switch_reg    <= switch_next;
      wait_reg      <= wait_next;
      wreq_reg      <= wreq_next;
      rdata_reg     <= rdata_next;
      act_reg       <= act_next;
    end
  end

  assign readdata    = rdata_reg;
  assign waitrequest = wreq_reg;

  // ------------------------------------------------------------
  // source select, edge detect and run gating
  // ------------------------------------------------------------
  logic src_level;
  logic src_prev_reg;
  logic src_edge;
  logic run_ok;
  logic bus_source;

  always_comb begin
    if (sel_reg < 4'(refclk_pkg::NUM_SOURCES)) begin
      src_level = sync2_reg[sel_reg];
    end else begin
      src_level = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  assign src_edge   = src_level && !src_prev_reg;
  assign bus_source = (sel_reg == refclk_pkg::SRC_SYSTEM) ||
                      (sel_reg == refclk_pkg::SRC_PERIPHERAL);
  // bus clocks stop in sleep, so the run-in-sleep bit does not matter there
  assign run_ok     = enable_reg &&
                      (!sleep2_reg || (sleep_run_reg && !bus_source));
  assign active     = run_ok;

  // ------------------------------------------------------------
  // fractional divider: output toggles every divider+trim/512 edges
  // ------------------------------------------------------------
  logic [14:0] cnt_reg,  cnt_next;
  logic [9:0]  frac_reg, frac_next;
  logic        out_reg,  out_next;
  logic        toggle;

  always_comb begin
    cnt_next  = cnt_reg;
    frac_next = frac_reg;
    out_next  = out_reg;
    toggle    = 1'b0;
    if (!run_ok) begin
      cnt_next  = 15'h0000;
      frac_next = 10'h000;
      out_next  = 1'b0;
    end else if (src_edge) begin
      if (act_reg.divider == 15'h0000) begin
        toggle = 1'b1;
      end else if (cnt_reg >= act_reg.divider - 15'h0001 + 15'(frac_reg[9])) begin
        toggle    = 1'b1;
        cnt_next  = 15'h0000;
        frac_next = {1'b0, frac_reg[8:0]} + {1'b0, act_reg.trim};
      end else begin
        cnt_next = cnt_reg + 15'h0001;
      end
      if (toggle) begin
        out_next = !out_reg;
      end
    end
  end

  // boundary: falling output edge or output idle
  assign boundary = !run_ok || (toggle && out_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= 15'h0000;
      frac_reg <= 10'h000;
      out_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      frac_reg <= frac_next;
      out_reg  <= out_next;
    end
  end

  assign reference_out = out_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence switch_armed;
    enable_reg && switch_reg && !boundary;
  endsequence

  property hold_until_boundary;
    @(posedge clk) disable iff (rst)
      switch_armed |=> $stable(act_reg);
  endproperty

  AST_SWITCH_HOLDS: assert property (hold_until_boundary)
    else $error("active divider changed before boundary");

  AST_SWITCH_LOADS: assert property (@(posedge clk) disable iff (rst)
    enable_reg && switch_reg && boundary |=>
      act_reg.divider == $past(div_pend_reg) && act_reg.trim == $past(trim_pend_reg))
    else $error("pending set not loaded at boundary");

  AST_SWITCH_CLEARS: assert property (@(posedge clk) disable iff (rst)
    enable_reg && switch_reg && boundary && !wr_ctl |=> !switch_reg)
    else $error("switch bit not cleared");

  AST_TRIM_HELD: assert property (@(posedge clk) disable iff (rst)
    enable_reg && !switch_reg && enable_next |=> $stable(act_reg.trim))
    else $error("trim took effect without switch");

  AST_OFF_IDLE: assert property (@(posedge clk) disable iff (rst)
    !enable_reg ##1 !enable_reg |-> !reference_out)
    else $error("output runs while disabled");

  AST_SLEEP_BUS: assert property (@(posedge clk) disable iff (rst)
    sleep2_reg && bus_source |-> !active)
    else $error("bus source runs in sleep");

  AST_SLEEP_STOP: assert property (@(posedge clk) disable iff (rst)
    sleep2_reg && !sleep_run_reg |=> !reference_out)
    else $error("output runs in sleep");

  AST_ACTIVE_READ: assert property (@(posedge clk) disable iff (rst)
    read && !wait_reg && address == refclk_pkg::ADDR_CONTROL |=>
      readdata[refclk_pkg::ACTIVE_BIT] == $past(active))
    else $error("active status misreported");

  AST_TRIM_READ: assert property (@(posedge clk) disable iff (rst)
    read && !wait_reg && address == refclk_pkg::ADDR_TRIM |=> readdata[22:0] == 23'h000000)
    else $error("trim reserved bits nonzero");

  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no answer in one cycle");

endmodule // reference_clock_generator
`default_nettype wire

/* File: core/refclk_pkg.sv */
// shared constants and types for the reference clock generator
package refclk_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TRIM    = 4'h4;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int DIV_LSB     = 16;
  localparam int DIV_W       = 15;
  localparam int ENABLE_BIT  = 15;
  localparam int SLEEP_BIT   = 11;
  localparam int SWITCH_BIT  = 9;
  localparam int ACTIVE_BIT  = 8;
  localparam int SEL_LSB     = 0;
  localparam int SEL_W       = 4;
  localparam int TRIM_LSB    = 23;
  localparam int TRIM_W      = 9;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [14:0] DIV_RESET  = 15'h0000;
  localparam logic [8:0]  TRIM_RESET = 9'h000;
  localparam logic [3:0]  SEL_RESET  = 4'h0;

  // ------------------------------------------------------------
  // source codes
  // ------------------------------------------------------------
  localparam logic [3:0] SRC_SYSTEM     = 4'h0;
  localparam logic [3:0] SRC_PERIPHERAL = 4'h1;
  localparam logic [3:0] SRC_PRIMARY    = 4'h2;
  localparam logic [3:0] SRC_FAST_RC    = 4'h3;
  localparam logic [3:0] SRC_LOW_RC     = 4'h4;
  localparam logic [3:0] SRC_SECONDARY  = 4'h5;
  localparam logic [3:0] SRC_USB_PLL    = 4'h6;
  localparam logic [3:0] SRC_SYS_PLL    = 4'h7;
  localparam logic [3:0] SRC_EXTERNAL   = 4'h8;
  localparam int         NUM_SOURCES    = 9;

  typedef struct packed {
    logic [14:0] divider;
    logic [8:0]  trim;
  } divider_set_type;

endpackage

/* File: dv/tb_top.sv */
// self-checking bench for the reference clock generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                                   clk = 1'b0;
  logic                                   rst = 1'b1;
  logic [3:0]                             address = 4'h0;
  logic                                   read = 1'b0;
  logic                                   write = 1'b0;
  logic [31:0]                            writedata = 32'h00000000;
  logic [3:0]                             byteenable = 4'hF;
  logic [31:0]                            readdata;
  logic                                   waitrequest;
  logic [refclk_pkg::NUM_SOURCES-1:0]     source_clocks = '0;
  logic                                   sleep_mode = 1'b0;
  logic                                   reference_out;
  int                                     err_count = 0;
  int                                     check_count = 0;
  int                                     cycles = 0;
  int                                     half_cnt [9];
  logic [14:0]                            cur_div = 15'h0000;
  logic                                   cur_rs = 1'b0;
  logic [3:0]                             cur_sel = 4'h0;

  reference_clock_generator DUT (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .source_clocks(source_clocks), .sleep_mode(sleep_mode),
    .reference_out(reference_out));

  always #4 clk = ~clk;

  // ----------------------------------------------------------
  // sources: source n has a half period of 4+n clocks
  // ----------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      test_done();
    end
    for (int n = 0; n < 9; n++) begin
      if (half_cnt[n] >= 3 + n) begin
        half_cnt[n] = 0;
        source_clocks[n] <= ~source_clocks[n];
      end else begin
        half_cnt[n]++;
      end
    end
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int   k;
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) begin
        q = readdata;
        break;
      end
    end
    read  <= 1'b0;
    write <= 1'b0;
    if (k == 100) begin
      err_count++;
      test_done();
    end
  endtask

  task automatic wr_be(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wr_be(a, d, 4'hF);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    check(q & m, e);
  endtask

  function automatic logic [31:0] ctl(input logic [14:0] d, input logic en, input logic rs,
                                      input logic sw, input logic [3:0] s);
    ctl = (32'(d) << refclk_pkg::DIV_LSB) | (32'(en) << refclk_pkg::ENABLE_BIT)
        | (32'(rs) << refclk_pkg::SLEEP_BIT) | (32'(sw) << refclk_pkg::SWITCH_BIT)
        | (32'(s) << refclk_pkg::SEL_LSB);
  endfunction

  // disable, then enable with new settings, so nothing changes while active
  task automatic restart(input logic [14:0] d, input logic r, input logic [3:0] s);
    wr_be(refclk_pkg::ADDR_CONTROL, ctl(cur_div, 1'b0, cur_rs, 1'b0, cur_sel), 4'h2);
    wr(refclk_pkg::ADDR_CONTROL, ctl(d, 1'b1, r, 1'b0, s));
    cur_div = d;
    cur_rs  = r;
    cur_sel = s;
  endtask

  // period in clocks between the second and third rising edge
  task automatic measure(input int exp);
    int   k;
    int   rises;
    int   c;
    logic p;
    rises = 0;
    c = 0;
    @(negedge clk);
    p = reference_out;
    for (k = 0; k < 2000 && rises < 3; k++) begin
      @(negedge clk);
      if (rises == 2) c++;
      if (reference_out === 1'b1 && p === 1'b0) rises++;
      p = reference_out;
    end
    check(32'(c), 32'(exp));
  endtask

  task automatic quiet();
    int   c;
    logic p;
    c = 0;
    repeat (4) @(negedge clk);
    p = reference_out;
    repeat (150) begin
      @(negedge clk);
      if (reference_out !== p) c++;
      p = reference_out;
    end
    check(32'(c), 32'h00000000);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] q;
    int          k;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(refclk_pkg::ADDR_CONTROL, 32'hFFFFFFFF, 32'h00000000);
    rdchk(refclk_pkg::ADDR_TRIM, 32'hFFFFFFFF, 32'h00000000);
    wr(refclk_pkg::ADDR_TRIM, 32'hFFFFFFFF);
    rdchk(refclk_pkg::ADDR_TRIM, 32'hFFFFFFFF, 32'hFF800000);
    wr(refclk_pkg::ADDR_TRIM, 32'h00000000);
    wr_be(refclk_pkg::ADDR_TRIM, 32'hFFFFFFFF, 4'h3);
    rdchk(refclk_pkg::ADDR_TRIM, 32'hFFFFFFFF, 32'h00000000);
    wr(refclk_pkg::ADDR_CONTROL, ctl(15'h0005, 1'b0, 1'b1, 1'b0, 4'h4) | 32'h00000100);
    cur_div = 15'h0005;
    cur_rs  = 1'b1;
    cur_sel = 4'h4;
    rdchk(refclk_pkg::ADDR_CONTROL, 32'h7FFF8B0F, ctl(15'h0005, 1'b0, 1'b1, 1'b0, 4'h4));
    wr_be(refclk_pkg::ADDR_CONTROL, ctl(15'h7FFF, 1'b0, 1'b1, 1'b0, 4'h4), 4'h2);
    wr(4'h8, 32'hFFFFFFFF);
    rdchk(4'h8, 32'hFFFFFFFF, 32'h00000000);
    rdchk(refclk_pkg::ADDR_CONTROL, 32'h7FFF8B0F, ctl(15'h0005, 1'b0, 1'b1, 1'b0, 4'h4));
    quiet();
    check({31'h0, reference_out}, 32'h00000000);
    $display("test registers done");
    for (int n = 0; n < 9; n++) begin
      restart(15'h0001, 1'b0, 4'(n));
      measure(4 * (4 + n));
      rdchk(refclk_pkg::ADDR_CONTROL, 32'h00000100, 32'h00000100);
    end
    $display("test source select done");
    restart(15'h0002, 1'b0, 4'h3);
    measure(56);
    @(posedge clk) sleep_mode <= 1'b1;
    quiet();
    rdchk(refclk_pkg::ADDR_CONTROL, 32'h00000100, 32'h00000000);
    wr(refclk_pkg::ADDR_CONTROL, ctl(15'h0003, 1'b1, 1'b0, 1'b0, 4'h3));
    @(posedge clk) sleep_mode <= 1'b0;
    measure(56);
    wr_be(refclk_pkg::ADDR_CONTROL, ctl(15'h0003, 1'b1, 1'b0, 1'b1, 4'h3), 4'h2);
    for (k = 0; k < 40; k++) begin
      bus(1'b0, refclk_pkg::ADDR_CONTROL, 32'h00000000, 4'hF, q);
      if (q[refclk_pkg::SWITCH_BIT] === 1'b0) break;
    end
    check({31'h0, q[refclk_pkg::SWITCH_BIT]}, 32'h00000000);
    cur_div = 15'h0003;
    measure(84);
    $display("test divider switch done");
    restart(15'h0003, 1'b1, 4'h0);
    measure(48);
    @(posedge clk) sleep_mode <= 1'b1;
    quiet();
    rdchk(refclk_pkg::ADDR_CONTROL, 32'h00000100, 32'h00000000);
    @(posedge clk) sleep_mode <= 1'b0;
    restart(15'h0003, 1'b1, 4'h3);
    @(posedge clk) sleep_mode <= 1'b1;
    measure(84);
    @(posedge clk) sleep_mode <= 1'b0;
    $display("test sleep done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
